/* verilog/tsc_pkg.sv */
// Constants for the trace status and comparator block.
package tsc_pkg;
    localparam logic [3:0] ADDR_CMP_A_HIGH = 4'h0;
    localparam logic [3:0] ADDR_CMP_A_LOW = 4'h1;
    localparam logic [3:0] ADDR_CMP_B_HIGH = 4'h2;
    localparam logic [3:0] ADDR_CMP_B_LOW = 4'h3;
    localparam logic [3:0] ADDR_CMP_C_HIGH = 4'h4;
    localparam logic [3:0] ADDR_CMP_C_LOW = 4'h5;
    localparam logic [3:0] ADDR_DIRECTION = 4'h6;
    localparam logic [3:0] ADDR_CONTROL = 4'hc;
    localparam logic [3:0] ADDR_TRIGGER = 4'hd;
    localparam logic [3:0] ADDR_STATUS = 4'he;
    localparam logic [3:0] ADDR_COUNT = 4'hf;
    // Control register fields.
    localparam int CTL_ON_BIT = 7;
    localparam int CTL_ARM_BIT = 6;
    localparam int CTL_TAG_BIT = 5;
    localparam int CTL_BRK_BIT = 4;
    localparam int CTL_DEDUPE_BIT = 0;
    // Trigger register fields.
    localparam int TRG_SEL_BIT = 7;
    localparam int TRG_BEGIN_BIT = 6;
    // Direction register fields.
    localparam int DIR_A_QUAL_BIT = 3;
    localparam int DIR_A_SEL_BIT = 2;
    localparam int DIR_B_QUAL_BIT = 1;
    localparam int DIR_B_SEL_BIT = 0;
    // Status register fields.
    localparam int STS_A_BIT = 7;
    localparam int STS_B_BIT = 6;
    localparam int STS_C_BIT = 5;
    localparam int STS_ARM_BIT = 0;
    // Full trigger modes.
    localparam logic [3:0] MODE_A_AND_B = 4'h5;
    localparam logic [3:0] MODE_A_AND_NOT_B = 4'h6;
    // Reset values and FIFO depth in words.
    localparam logic [7:0] RST_CONTROL = 8'hc0;
    localparam logic [7:0] RST_TRIGGER = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h01;
    localparam logic [3:0] RST_COUNT = 4'h0;
    localparam logic [3:0] FIFO_WORDS = 4'h8;
endpackage

/* verilog/tsc_trace_status.sv */
// Trace status flags, fill count and the three comparators; B compares data in the full modes.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module tsc_trace_status
    import tsc_pkg::*;
(
    // Clock and resets.
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_sys_reset,
    // Register port.
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Core buses.
    input wire logic i_core_valid,
    input wire logic i_core_read,
    input wire logic [15:0] i_core_addr,
    input wire logic [7:0] i_core_rdata,
    input wire logic [7:0] i_core_wdata,
    // Trigger and break controller.
    input wire logic i_trigger_hit,
    input wire logic i_flow_change_event,
    input wire logic [15:0] i_flow_addr,
    output logic o_match_a,
    output logic o_match_b,
    output logic o_match_c,
    output logic o_capture_valid,
    output logic [15:0] o_capture_addr,
    output logic o_module_on
);
    logic [7:0] cmp_a_high_ff, cmp_a_low_ff;
    logic [7:0] cmp_b_high_ff, cmp_b_low_ff;
    logic [7:0] cmp_c_high_ff, cmp_c_low_ff;
    logic [3:0] dir_ff;
    logic [7:0] trigger_ff;
    logic module_on_ff, arm_ff, tag_ff, brk_ff, dedupe_ff;
    logic match_a_flag_ff, match_b_flag_ff, match_c_flag_ff;
    logic [3:0] fifo_fill_count_ff;
    logic [7:0] rdata_ff;
    logic match_a_ff, match_b_ff, match_c_ff;
    logic capture_valid_ff;
    logic [15:0] capture_addr_ff;

    logic end_run_reset, full_reset, full_mode, arm_start, running;
    logic write_sel, a_hit, b_hit, c_hit, c_equal, capture, fill_done;
    logic [7:0] data_sel;

    // A system reset ends an enabled end-trigger trace instead of wiping it.
    assign end_run_reset = i_sys_reset & module_on_ff &
                           ~trigger_ff[TRG_BEGIN_BIT];
    assign full_reset = i_reset | (i_sys_reset & ~end_run_reset);
    assign full_mode = (trigger_ff[3:0] == MODE_A_AND_B) ||
                       (trigger_ff[3:0] == MODE_A_AND_NOT_B);
    assign arm_start = i_wr && (i_addr == ADDR_CONTROL) &&
                       i_wdata[CTL_ARM_BIT] && i_wdata[CTL_ON_BIT] && !arm_ff;
    assign running = module_on_ff & arm_ff;

    // Comparisons.
    assign write_sel = dir_ff[DIR_A_QUAL_BIT] & ~dir_ff[DIR_A_SEL_BIT];
    assign data_sel = write_sel ? i_core_wdata : i_core_rdata;
    always_comb begin
        a_hit = i_core_valid &&
                (i_core_addr == {cmp_a_high_ff, cmp_a_low_ff});
        b_hit = 1'b0;
        if (full_mode) begin
            // Both comparators follow comparator A direction bits here.
            a_hit = a_hit && (i_core_read == !write_sel);
            b_hit = i_core_valid && (i_core_read == !write_sel) &&
                    (data_sel == cmp_b_low_ff);
        end else begin
            if (dir_ff[DIR_A_QUAL_BIT]) begin
                a_hit = a_hit && (i_core_read == dir_ff[DIR_A_SEL_BIT]);
            end
            b_hit = i_core_valid &&
                    (i_core_addr == {cmp_b_high_ff, cmp_b_low_ff});
            if (dir_ff[DIR_B_QUAL_BIT]) begin
                b_hit = b_hit && (i_core_read == dir_ff[DIR_B_SEL_BIT]);
            end
        end
        c_hit = i_core_valid && !dedupe_ff &&
                (i_core_addr == {cmp_c_high_ff, cmp_c_low_ff});
    end

    // Flow capture with duplicate suppression.
    assign c_equal = (i_flow_addr == {cmp_c_high_ff, cmp_c_low_ff});
    assign capture = running && i_flow_change_event &&
                     !(dedupe_ff && c_equal);
    assign fill_done = trigger_ff[TRG_BEGIN_BIT] && capture &&
                       (fifo_fill_count_ff == FIFO_WORDS - 4'h1);

    // Match strobes to the trigger and break controller.
    always_ff @(posedge i_clk) begin
        if (full_reset) begin
            match_a_ff <= 1'b0;
            match_b_ff <= 1'b0;
            match_c_ff <= 1'b0;
        end else begin
            match_a_ff <= module_on_ff & a_hit;
            match_b_ff <= module_on_ff & b_hit;
            match_c_ff <= module_on_ff & c_hit;
        end
    end

    // Control register.
    always_ff @(posedge i_clk) begin
        if (full_reset) begin
            module_on_ff <= RST_CONTROL[CTL_ON_BIT];
            arm_ff <= RST_CONTROL[CTL_ARM_BIT];
            tag_ff <= RST_CONTROL[CTL_TAG_BIT];
            brk_ff <= RST_CONTROL[CTL_BRK_BIT];
            dedupe_ff <= RST_CONTROL[CTL_DEDUPE_BIT];
        end else if (end_run_reset) begin
            arm_ff <= 1'b0;
            brk_ff <= 1'b0;
        end else if (i_wr && (i_addr == ADDR_CONTROL)) begin
            module_on_ff <= i_wdata[CTL_ON_BIT];
            arm_ff <= i_wdata[CTL_ARM_BIT] & i_wdata[CTL_ON_BIT];
            tag_ff <= i_wdata[CTL_TAG_BIT];
            brk_ff <= i_wdata[CTL_BRK_BIT];
            dedupe_ff <= i_wdata[CTL_DEDUPE_BIT];
        end else if (running && ((i_trigger_hit &&
                     !trigger_ff[TRG_BEGIN_BIT]) || fill_done)) begin
            arm_ff <= 1'b0;
        end else if (!module_on_ff) begin
            arm_ff <= 1'b0;
        end
    end

    // Trigger and direction registers; trigger setup is frozen while armed.
    always_ff @(posedge i_clk) begin
        if (full_reset) begin
            trigger_ff <= RST_TRIGGER;
            dir_ff <= 4'h0;
        end else if (i_wr && !end_run_reset) begin
            if (i_addr == ADDR_TRIGGER && !arm_ff) begin
                trigger_ff <= {i_wdata[7:6], 2'b00, i_wdata[3:0]};
            end else if (i_addr == ADDR_DIRECTION) begin
                dir_ff <= i_wdata[3:0];
            end
        end
    end

    // Comparator A and B value registers.
    always_ff @(posedge i_clk) begin
        if (full_reset) begin
            cmp_a_high_ff <= 8'h00;
            cmp_a_low_ff <= 8'h00;
            cmp_b_high_ff <= 8'h00;
            cmp_b_low_ff <= 8'h00;
        end else if (i_wr && !end_run_reset) begin
            if (i_addr == ADDR_CMP_A_HIGH) begin
                cmp_a_high_ff <= i_wdata;
            end else if (i_addr == ADDR_CMP_A_LOW) begin
                cmp_a_low_ff <= i_wdata;
            end else if (i_addr == ADDR_CMP_B_HIGH) begin
                cmp_b_high_ff <= i_wdata;
            end else if (i_addr == ADDR_CMP_B_LOW) begin
                cmp_b_low_ff <= i_wdata;
            end
        end
    end

    // Comparator C: software value, or tracked flow address in dedupe mode.
    always_ff @(posedge i_clk) begin
        if (full_reset) begin
            cmp_c_high_ff <= 8'h00;
            cmp_c_low_ff <= 8'h00;
        end else if (end_run_reset) begin
            cmp_c_high_ff <= cmp_c_high_ff;
        end else if (arm_start && i_wdata[CTL_DEDUPE_BIT]) begin
            cmp_c_high_ff <= 8'h00;
            cmp_c_low_ff <= 8'h00;
        end else if (capture && dedupe_ff) begin
            cmp_c_high_ff <= i_flow_addr[15:8];
            cmp_c_low_ff <= i_flow_addr[7:0];
        end else if (i_wr && (i_addr == ADDR_CMP_C_HIGH)) begin
            cmp_c_high_ff <= i_wdata;
        end else if (i_wr && (i_addr == ADDR_CMP_C_LOW)) begin
            cmp_c_low_ff <= i_wdata;
        end
    end

    // Sticky match flags; flags survive a trace-ending reset.
    always_ff @(posedge i_clk) begin
        if (full_reset) begin
            match_a_flag_ff <= RST_STATUS[STS_A_BIT];
            match_b_flag_ff <= RST_STATUS[STS_B_BIT];
            match_c_flag_ff <= RST_STATUS[STS_C_BIT];
        end else if (end_run_reset) begin
            match_a_flag_ff <= match_a_flag_ff;
        end else if (arm_start) begin
            match_a_flag_ff <= 1'b0;
            match_b_flag_ff <= 1'b0;
            match_c_flag_ff <= 1'b0;
        end else if (running) begin
            match_a_flag_ff <= match_a_flag_ff | a_hit;
            match_b_flag_ff <= match_b_flag_ff | b_hit;
            match_c_flag_ff <= match_c_flag_ff | c_hit;
        end
    end

    // Valid-word count; it never counts down on readout.
    always_ff @(posedge i_clk) begin
        if (full_reset) begin
            fifo_fill_count_ff <= RST_COUNT;
        end else if (end_run_reset) begin
            fifo_fill_count_ff <= fifo_fill_count_ff;
        end else if (arm_start) begin
            fifo_fill_count_ff <= RST_COUNT;
        end else if (capture && fifo_fill_count_ff != FIFO_WORDS) begin
            fifo_fill_count_ff <= fifo_fill_count_ff + 4'h1;
        end
    end

    // Captured word handed to the FIFO.
    always_ff @(posedge i_clk) begin
        if (full_reset) begin
            capture_valid_ff <= 1'b0;
            capture_addr_ff <= 16'h0000;
        end else begin
            capture_valid_ff <= capture & ~end_run_reset;
            if (capture) begin
                capture_addr_ff <= i_flow_addr;
            end
        end
    end

    // Read data, one cycle after the strobe; status and count ignore writes.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_ff <= 8'h00;
        end else if (!i_rd) begin
            rdata_ff <= 8'h00;
        end else if (i_addr == ADDR_STATUS) begin
            rdata_ff <= {match_a_flag_ff, match_b_flag_ff, match_c_flag_ff,
                         4'h0, arm_ff & module_on_ff};
        end else if (i_addr == ADDR_COUNT) begin
            rdata_ff <= {4'h0, fifo_fill_count_ff};
        end else if (i_addr == ADDR_CONTROL) begin
            rdata_ff <= {module_on_ff, arm_ff, tag_ff, brk_ff, 3'b000,
                         dedupe_ff};
        end else if (i_addr == ADDR_TRIGGER) begin
            rdata_ff <= trigger_ff;
        end else if (i_addr == ADDR_DIRECTION) begin
            rdata_ff <= {4'h0, dir_ff};
        end else if (i_addr == ADDR_CMP_A_HIGH) begin
            rdata_ff <= cmp_a_high_ff;
        end else if (i_addr == ADDR_CMP_A_LOW) begin
            rdata_ff <= cmp_a_low_ff;
        end else if (i_addr == ADDR_CMP_B_HIGH) begin
            rdata_ff <= cmp_b_high_ff;
        end else if (i_addr == ADDR_CMP_B_LOW) begin
            rdata_ff <= cmp_b_low_ff;
        end else if (i_addr == ADDR_CMP_C_HIGH) begin
            rdata_ff <= cmp_c_high_ff;
        end else if (i_addr == ADDR_CMP_C_LOW) begin
            rdata_ff <= cmp_c_low_ff;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_match_a = match_a_ff;
    assign o_match_b = match_b_ff;
    assign o_match_c = match_c_ff;
    assign o_capture_valid = capture_valid_ff;
    assign o_capture_addr = capture_addr_ff;
    assign o_module_on = module_on_ff;

    a_flag_a_set: assert property (@(posedge i_clk)
        disable iff (full_reset)
        running && a_hit && !arm_start && !end_run_reset |=> match_a_flag_ff)
        else $error("flag A not set after match");

    a_arm_status: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_rd && i_addr == ADDR_STATUS |=>
        o_rdata[0] == $past(arm_ff & module_on_ff))
        else $error("armed status bit wrong");

    a_reset_values: assert property (@(posedge i_clk)
        full_reset |=> !match_a_flag_ff && !match_b_flag_ff &&
        !match_c_flag_ff && arm_ff)
        else $error("reset values wrong");

    a_end_run_keep: assert property (@(posedge i_clk)
        disable iff (i_reset)
        end_run_reset |=> !arm_ff && $stable(match_a_flag_ff) &&
        $stable(match_b_flag_ff) && $stable(match_c_flag_ff) &&
        $stable(fifo_fill_count_ff))
        else $error("end-run reset disturbed state");

    a_count_range: assert property (@(posedge i_clk)
        disable iff (i_reset)
        fifo_fill_count_ff <= FIFO_WORDS)
        else $error("count beyond eight");

    a_count_sat: assert property (@(posedge i_clk)
        disable iff (full_reset)
        fifo_fill_count_ff == FIFO_WORDS && !arm_start |=>
        fifo_fill_count_ff == FIFO_WORDS)
        else $error("count left saturation");

    a_count_step: assert property (@(posedge i_clk)
        disable iff (full_reset)
        capture && !arm_start && !end_run_reset &&
        fifo_fill_count_ff < FIFO_WORDS |=>
        fifo_fill_count_ff == $past(fifo_fill_count_ff) + 4'h1)
        else $error("count did not advance");

    a_idle_off: assert property (@(posedge i_clk)
        disable iff (full_reset)
        !module_on_ff |=> !capture_valid_ff && !match_a_ff)
        else $error("activity while module off");

    a_cmp_a_match: assert property (@(posedge i_clk)
        disable iff (full_reset)
        module_on_ff && i_core_valid && !full_mode &&
        !dir_ff[DIR_A_QUAL_BIT] &&
        i_core_addr == {cmp_a_high_ff, cmp_a_low_ff} |=> match_a_ff)
        else $error("comparator A missed its address");

    a_full_write: assert property (@(posedge i_clk)
        disable iff (full_reset)
        module_on_ff && full_mode && i_core_valid && !i_core_read &&
        dir_ff[DIR_A_QUAL_BIT] && !dir_ff[DIR_A_SEL_BIT] &&
        i_core_wdata == cmp_b_low_ff |=> match_b_ff)
        else $error("full mode write data compare missed");

    a_full_read: assert property (@(posedge i_clk)
        disable iff (full_reset)
        module_on_ff && full_mode && i_core_valid && i_core_read &&
        !(dir_ff[DIR_A_QUAL_BIT] && !dir_ff[DIR_A_SEL_BIT]) &&
        i_core_rdata == cmp_b_low_ff |=> match_b_ff)
        else $error("full mode read data compare missed");

    a_cmp_c_match: assert property (@(posedge i_clk)
        disable iff (full_reset)
        module_on_ff && !dedupe_ff && i_core_valid &&
        i_core_addr == {cmp_c_high_ff, cmp_c_low_ff} |=> match_c_ff)
        else $error("comparator C missed its address");

    a_c_no_break: assert property (@(posedge i_clk)
        disable iff (full_reset)
        dedupe_ff |=> !match_c_ff)
        else $error("comparator C matched in dedupe mode");

    a_c_arm_clear: assert property (@(posedge i_clk)
        disable iff (full_reset)
        arm_start && i_wdata[CTL_DEDUPE_BIT] && !end_run_reset |=>
        {cmp_c_high_ff, cmp_c_low_ff} == 16'h0000)
        else $error("comparator C not cleared on arming");

    a_dedupe_skip: assert property (@(posedge i_clk)
        disable iff (full_reset)
        dedupe_ff && i_flow_change_event && c_equal |=> !capture_valid_ff)
        else $error("duplicate flow address captured");

    a_c_tracks: assert property (@(posedge i_clk)
        disable iff (full_reset)
        capture && dedupe_ff && !end_run_reset && !arm_start |=>
        {cmp_c_high_ff, cmp_c_low_ff} == $past(i_flow_addr))
        else $error("comparator C did not track");

    a_end_disarm: assert property (@(posedge i_clk)
        disable iff (full_reset)
        running && i_trigger_hit && !trigger_ff[TRG_BEGIN_BIT] && !i_wr |=>
        !arm_ff)
        else $error("arm survived end trigger");

    a_arm_clears: assert property (@(posedge i_clk)
        disable iff (full_reset)
        arm_start && !end_run_reset |=> !match_a_flag_ff &&
        !match_b_flag_ff && !match_c_flag_ff &&
        fifo_fill_count_ff == RST_COUNT)
        else $error("arming did not clear state");

    a_status_zeros: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_rd && i_addr == ADDR_STATUS |=> o_rdata[4:1] == 4'h0)
        else $error("status unused bits not zero");

    a_count_zeros: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_rd && i_addr == ADDR_COUNT |=> o_rdata[7:4] == 4'h0)
        else $error("count unused bits not zero");
endmodule

/* dv/tsc_core_model.sv */
// Partner model of the core buses and the trigger controller.
`timescale 1ns/100ps
module tsc_core_model (
    // Clock.
    input wire logic i_clk,
    // Core buses.
    output logic o_core_valid,
    output logic o_core_read,
    output logic [15:0] o_core_addr,
    output logic [7:0] o_core_rdata,
    output logic [7:0] o_core_wdata,
    // Trigger controller requests.
    output logic o_trigger_hit,
    output logic o_flow_change_event,
    output logic [15:0] o_flow_addr
);
    initial begin
        o_core_valid = 1'b0;
        o_core_read = 1'b0;
        o_core_addr = 16'h0000;
        o_core_rdata = 8'h00;
        o_core_wdata = 8'h00;
        o_trigger_hit = 1'b0;
        o_flow_change_event = 1'b0;
        o_flow_addr = 16'h0000;
    end

    // The unused data bus and released buses show inverted values.
    task automatic access(input logic [15:0] a, input logic rd,
                          input logic [7:0] d);
        @(posedge i_clk);
        o_core_valid <= 1'b1;
        o_core_read <= rd;
        o_core_addr <= a;
        o_core_rdata <= rd ? d : ~d;
        o_core_wdata <= rd ? ~d : d;
        @(posedge i_clk);
        o_core_valid <= 1'b0;
        o_core_addr <= ~a;
        o_core_rdata <= ~d;
        o_core_wdata <= ~d;
    endtask

    task automatic flow(input logic [15:0] a);
        @(posedge i_clk);
        o_flow_change_event <= 1'b1;
        o_flow_addr <= a;
        @(posedge i_clk);
        o_flow_change_event <= 1'b0;
        o_flow_addr <= ~a;
    endtask

    task automatic hit();
        @(posedge i_clk);
        o_trigger_hit <= 1'b1;
        @(posedge i_clk);
        o_trigger_hit <= 1'b0;
    endtask
endmodule

/* dv/testbench.sv */
// Self-checking testbench for the trace status and comparator block.
`timescale 1ns/100ps
module testbench;
    import tsc_pkg::*;
    logic i_clk, i_reset, i_sys_reset, i_wr, i_rd;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, core_rdata, core_wdata;
    logic core_valid, core_read, trig_hit, flow_ev;
    logic [15:0] core_addr, flow_addr, o_capture_addr;
    logic o_match_a, o_match_b, o_match_c, o_capture_valid, o_module_on;
    int n_errors = 0;
    int n_compared = 0;

    tsc_core_model tsc_core_model_inst (.i_clk(i_clk),
        .o_core_valid(core_valid), .o_core_read(core_read),
        .o_core_addr(core_addr), .o_core_rdata(core_rdata),
        .o_core_wdata(core_wdata), .o_trigger_hit(trig_hit),
        .o_flow_change_event(flow_ev), .o_flow_addr(flow_addr));

    tsc_trace_status tsc_trace_status_inst (.i_clk(i_clk),
        .i_reset(i_reset), .i_sys_reset(i_sys_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_core_valid(core_valid), .i_core_read(core_read),
        .i_core_addr(core_addr), .i_core_rdata(core_rdata),
        .i_core_wdata(core_wdata), .i_trigger_hit(trig_hit),
        .i_flow_change_event(flow_ev), .i_flow_addr(flow_addr),
        .o_match_a(o_match_a), .o_match_b(o_match_b),
        .o_match_c(o_match_c), .o_capture_valid(o_capture_valid),
        .o_capture_addr(o_capture_addr), .o_module_on(o_module_on));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic end_sim();
        $display("Errors %0d, compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                          input logic [7:0] m);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk($sformatf("register %h", a), {8'h00, e & m}, {8'h00, o_rdata & m});
    endtask

    task automatic pulse_reset(input logic sys);
        @(posedge i_clk);
        if (sys) begin
            i_sys_reset <= 1'b1;
        end else begin
            i_reset <= 1'b1;
        end
        @(posedge i_clk);
        i_sys_reset <= 1'b0;
        i_reset <= 1'b0;
    endtask

    task automatic t_reset();
        rd_chk(ADDR_STATUS, RST_STATUS, 8'hff);
        rd_chk(ADDR_COUNT, 8'h00, 8'hff);
        wr(ADDR_STATUS, 8'hfe);
        wr(ADDR_COUNT, 8'hff);
        rd_chk(ADDR_STATUS, RST_STATUS, 8'hff);
        rd_chk(ADDR_COUNT, 8'h00, 8'hff);
        rd_chk(4'h8, 8'h00, 8'hff);
    endtask

    task automatic t_match();
        wr(ADDR_CMP_A_HIGH, 8'h12);
        wr(ADDR_CMP_A_LOW, 8'h34);
        wr(ADDR_CMP_C_HIGH, 8'h43);
        wr(ADDR_CMP_C_LOW, 8'h21);
        tsc_core_model_inst.access(16'h1234, 1'b0, 8'h00);
        #1;
        chk("match_a", 16'h0001, {15'h0, o_match_a});
        chk("match_c", 16'h0000, {15'h0, o_match_c});
        rd_chk(ADDR_STATUS, 8'h81, 8'hff);
        tsc_core_model_inst.access(16'h4321, 1'b1, 8'h00);
        #1;
        chk("match_c", 16'h0001, {15'h0, o_match_c});
        rd_chk(ADDR_STATUS, 8'ha1, 8'hff);
    endtask

    task automatic t_count();
        for (int i = 0; i < 9; i++) begin
            tsc_core_model_inst.flow(16'h0100 + 16'(i));
            #1;
            chk("capture_valid", 16'h0001, {15'h0, o_capture_valid});
            chk("capture_addr", 16'h0100 + 16'(i), o_capture_addr);
            rd_chk(ADDR_COUNT, (i < 8) ? 8'(i + 1) : 8'h08, 8'hff);
        end
        rd_chk(ADDR_COUNT, 8'h08, 8'hff);
    endtask

    task automatic t_resets();
        pulse_reset(1'b1);
        rd_chk(ADDR_STATUS, 8'ha0, 8'hff);
        rd_chk(ADDR_COUNT, 8'h08, 8'hff);
        pulse_reset(1'b0);
        rd_chk(ADDR_STATUS, RST_STATUS, 8'hff);
        rd_chk(ADDR_COUNT, 8'h00, 8'hff);
    endtask

    task automatic t_arm();
        tsc_core_model_inst.flow(16'h0200);
        tsc_core_model_inst.access(16'h0000, 1'b1, 8'h00);
        wr(ADDR_CONTROL, 8'h80);
        rd_chk(ADDR_STATUS, 8'he0, 8'hff);
        wr(ADDR_CONTROL, 8'hc0);
        rd_chk(ADDR_STATUS, 8'h01, 8'hff);
        rd_chk(ADDR_COUNT, 8'h00, 8'hff);
    endtask

    task automatic t_dedupe();
        wr(ADDR_CMP_C_HIGH, 8'h55);
        wr(ADDR_CMP_C_LOW, 8'h55);
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_CONTROL, 8'hc1);
        rd_chk(ADDR_CMP_C_HIGH, 8'h00, 8'hff);
        rd_chk(ADDR_CMP_C_LOW, 8'h00, 8'hff);
        tsc_core_model_inst.flow(16'h2222);
        tsc_core_model_inst.flow(16'h2222);
        #1;
        chk("capture_valid", 16'h0000, {15'h0, o_capture_valid});
        rd_chk(ADDR_COUNT, 8'h01, 8'hff);
        tsc_core_model_inst.flow(16'h3333);
        rd_chk(ADDR_COUNT, 8'h02, 8'hff);
        rd_chk(ADDR_CMP_C_HIGH, 8'h33, 8'hff);
        rd_chk(ADDR_CMP_C_LOW, 8'h33, 8'hff);
        tsc_core_model_inst.access(16'h3333, 1'b1, 8'h00);
        #1;
        chk("match_c", 16'h0000, {15'h0, o_match_c});
    endtask

    task automatic t_full();
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_TRIGGER, {4'h0, MODE_A_AND_B});
        wr(ADDR_CMP_B_HIGH, 8'h00);
        wr(ADDR_CMP_B_LOW, 8'h5a);
        wr(ADDR_DIRECTION, 8'h0b);
        wr(ADDR_CONTROL, 8'hc0);
        tsc_core_model_inst.access(16'h3000, 1'b0, 8'h5a);
        #1;
        chk("match_b", 16'h0001, {15'h0, o_match_b});
        tsc_core_model_inst.access(16'h3000, 1'b1, 8'h5a);
        #1;
        chk("match_b", 16'h0000, {15'h0, o_match_b});
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_TRIGGER, {4'h0, MODE_A_AND_NOT_B});
        wr(ADDR_DIRECTION, 8'h00);
        wr(ADDR_CONTROL, 8'hc0);
        tsc_core_model_inst.access(16'h3000, 1'b1, 8'h5a);
        #1;
        chk("match_b", 16'h0001, {15'h0, o_match_b});
        tsc_core_model_inst.hit();
        rd_chk(ADDR_STATUS, 8'h00, 8'h01);
    endtask

    // Begin-trigger run: the eighth capture disarms, then a system reset wipes the trace.
    task automatic t_begin();
        wr(ADDR_TRIGGER, 8'h40);
        wr(ADDR_CONTROL, 8'hc0);
        for (int i = 0; i < 8; i++) begin
            tsc_core_model_inst.flow(16'h0500 + 16'(i));
        end
        rd_chk(ADDR_STATUS, 8'h00, 8'h01);
        rd_chk(ADDR_COUNT, 8'h08, 8'hff);
        tsc_core_model_inst.flow(16'h0600);
        #1;
        chk("capture_valid", 16'h0000, {15'h0, o_capture_valid});
        pulse_reset(1'b1);
        rd_chk(ADDR_STATUS, RST_STATUS, 8'hff);
        rd_chk(ADDR_COUNT, 8'h00, 8'hff);
    endtask

    task automatic t_off();
        wr(ADDR_CMP_A_HIGH, 8'h12);
        wr(ADDR_CMP_A_LOW, 8'h34);
        wr(ADDR_CONTROL, 8'h00);
        #1;
        chk("module_on", 16'h0000, {15'h0, o_module_on});
        tsc_core_model_inst.access(16'h1234, 1'b1, 8'h00);
        #1;
        chk("match_a", 16'h0000, {15'h0, o_match_a});
        tsc_core_model_inst.flow(16'h0400);
        #1;
        chk("capture_valid", 16'h0000, {15'h0, o_capture_valid});
    endtask

    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        end_sim();
    end

    initial begin
        i_reset = 1'b1;
        i_sys_reset = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_match();
        t_count();
        t_resets();
        t_arm();
        t_dedupe();
        t_full();
        t_begin();
        t_off();
        end_sim();
    end
endmodule
